/* File: tb/pmpsc_board.sv */
// Board-side pin model feeding pad levels back into the device
`timescale 1ns/1ps
module pmpsc_board #(
    parameter int N = 8
) (
    input  wire logic         pclk,
    input  wire logic [N-1:0] pad_out,
    input  wire logic [N-1:0] pad_oe_n,
    input  wire logic [N-1:0] pad_pu,
    output logic      [N-1:0] pad_in
);
    logic [N-1:0] float_q = '0;

    // Undriven pins without pull-up wander, so a stale level never passes
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : (pad_pu[i] ? 1'b1 : float_q[i]);
        end
    end
endmodule : pmpsc_board

/* File: tb/pmpsc_top_tb.sv */
// Self-checking bench for the pin state control block
`timescale 1ns/1ps
module pmpsc_top_tb;
    import pmpsc_pkg::*;
    localparam int NP = 8;
    localparam logic [31:0] FUNC_V = 32'h00fac688;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          ce = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = '0;
    logic [31:0]   pwdata = '0;
    logic [31:0]   prdata, rd;
    logic          pready, pslverr, err;
    logic          external_reset_input_n = 1'b0;
    logic          int_reset = 1'b0;
    pmpsc_pwr_t    pwr_mode = PWR_RUN;
    logic          osc_stopped = 1'b0;
    logic [NP-1:0] per_oe = '0;
    logic [NP-1:0] per_out = 8'ha5;
    logic [NP-1:0] goe_v = '0;
    logic [NP-1:0] pad_in, pad_out, pad_oe_n, pad_pu, pad_ie, pad_ae;
    logic [NP-1:0] wakeup_input_en, pin_in_core;
    logic          ext_rst_pu, ext_rst_ie, mode_pin_ie, osc_in_ie, osc_out_oe_n, osc_out_ie;
    pmpsc_state_t  power_state;
    int            error_cnt = 0;
    int            tests_run = 0;

    pmpsc_top #(.NPINS(NP)) dut_u (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .external_reset_input_n, .int_reset, .pwr_mode,
        .osc_stopped, .per_oe, .per_out, .pad_in, .pad_out, .pad_oe_n, .pad_pu,
        .pad_ie, .pad_ae, .wakeup_input_en, .pin_in_core, .ext_rst_pu, .ext_rst_ie,
        .mode_pin_ie, .osc_in_ie, .osc_out_oe_n, .osc_out_ie, .power_state
    );

    pmpsc_board #(.N(NP)) board_u (.pclk, .pad_out, .pad_oe_n, .pad_pu, .pad_in);

    always #5 pclk = ~pclk;

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        check(32'(err), 32'(e));
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // Expected drive enable, pin i carries function code i
    function automatic logic ref_oe_n(input logic [2:0] f, input pmpsc_state_t s,
                                      input logic lvl, input logic poe, input logic goe);
        if (s inside {ST_POR, ST_XRST, ST_IRST} || f == FN_ANALOG || f == 3'h7) return 1'b1;
        if (f == FN_DEBUG) return !poe;
        if (s == ST_RUN) return (f == FN_GPIO) ? !goe : !poe;
        if (lvl && (s == ST_DEEP || (s == ST_STBY && f inside {FN_GPIO, FN_RESRC})))
            return 1'b1;
        if (s == ST_STBY) return (f == FN_GPIO) ? !goe : !poe;
        return !goe;
    endfunction : ref_oe_n

    task automatic chk_pins(input pmpsc_state_t s, input logic lvl);
        logic [NP-1:0] eoe, eae, ewk;
        for (int i = 0; i < NP; i++) begin
            eoe[i] = ref_oe_n(3'(i), s, lvl, per_oe[i], goe_v[i]);
            eae[i] = (i == 3) && (s != ST_POR);
            ewk[i] = (i == 2 || i == 6) && (s == ST_DEEP);
        end
        check(32'(power_state), 32'(s));
        check(32'(pad_oe_n), 32'(eoe));
        check(32'(pad_ae), 32'(eae));
        check(32'(wakeup_input_en), 32'(ewk));
    endtask : chk_pins

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge pclk);
        check({ext_rst_pu, ext_rst_ie, mode_pin_ie, osc_in_ie}, 32'hf);
        check({osc_out_oe_n, osc_out_ie}, 32'h2);
        chk_pins(ST_POR, 1'b0);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check(32'(power_state), 32'(ST_XRST));
        check({pad_oe_n, ext_rst_pu, ext_rst_ie}, 32'h3ff);
        wr(ADDR_FUNC, FUNC_V, 1'b1);
        rdchk(ADDR_FUNC, 32'h0);
        rdchk(12'h020, 32'h0);
        check(32'(err), 32'h1);
        external_reset_input_n <= 1'b1;
        repeat (6) @(posedge pclk);
        check(32'(power_state), 32'(ST_RUN));
        wr(ADDR_FUNC, FUNC_V, 1'b0);
        rdchk(ADDR_FUNC, FUNC_V);
        rdchk(ADDR_STBY_CTL, 32'h0);
        rdchk(ADDR_STATUS, 32'h3);
        // Port value and peripheral value differ so the source shows
        per_oe <= 8'hff;
        wr(ADDR_GOUT, 32'h5a, 1'b0);
        wr(ADDR_GOE, 32'hff, 1'b0);
        repeat (3) @(posedge pclk);
        check({pad_out[1:0], pad_oe_n[1:0]}, 32'h0);
        check({osc_out_oe_n, pin_in_core[3]}, 32'h0);
        osc_stopped <= 1'b1;
        repeat (3) @(posedge pclk);
        check({osc_out_oe_n, osc_out_ie}, 32'h2);
        osc_stopped <= 1'b0;
        // Driven pins loop back; analog and code 7 pins float, so they are masked
        check(32'(pin_in_core), 32'h24);
        apb(1'b0, ADDR_PADIN, 32'h0);
        check(rd & 32'h77, 32'h24);
        for (int k = 0; k < 2; k++) begin
            goe_v = (k == 0) ? 8'hff : 8'h00;
            per_oe <= ~goe_v;
            wr(ADDR_GOE, 32'(goe_v), 1'b0);
            for (int sp = 0; sp < 2; sp++) begin
                wr(ADDR_STBY_CTL, 32'(sp), 1'b0);
                rdchk(ADDR_STBY_CTL, 32'(sp));
                for (int m = 0; m < 4; m++) begin
                    pwr_mode <= pmpsc_pwr_t'(m);
                    repeat (3) @(posedge pclk);
                    chk_pins(pmpsc_state_t'(m + 3), sp[0]);
                end
                pwr_mode <= PWR_RUN;
                repeat (3) @(posedge pclk);
            end
        end
        int_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_pins(ST_IRST, 1'b1);
        check({pad_pu[1], pad_ie[1], pad_ie[5], pad_ie[3], pin_in_core[3]}, 32'h1c);
        check({osc_out_oe_n, osc_out_ie}, 32'h2);
        wr(ADDR_GOE, 32'h0, 1'b1);
        int_reset <= 1'b0;
        repeat (3) @(posedge pclk);
        check(32'(power_state), 32'(ST_RUN));
        // A stalled clock enable must freeze the state
        ce <= 1'b0;
        pwr_mode <= PWR_DEEP;
        repeat (3) @(posedge pclk);
        check(32'(power_state), 32'(ST_RUN));
        ce <= 1'b1;
        repeat (3) @(posedge pclk);
        check(32'(power_state), 32'(ST_DEEP));
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({pad_oe_n, pad_ae}, 32'hff00);
        complete_run();
    end
endmodule : pmpsc_top_tb

/* File: verilog/pmpsc_pkg.sv */
// Constants and types for the power mode pin state control block
package pmpsc_pkg;

    // Register byte offsets
    localparam logic [11:0] ADDR_STBY_CTL = 12'h000;
    localparam logic [11:0] ADDR_FUNC     = 12'h004;
    localparam logic [11:0] ADDR_GOUT     = 12'h008;
    localparam logic [11:0] ADDR_GOE      = 12'h00c;
    localparam logic [11:0] ADDR_STATUS   = 12'h010;
    localparam logic [11:0] ADDR_PADIN    = 12'h014;

    // Field positions
    localparam int LVL_SEL_BIT   = 0;
    localparam int FUNC_W        = 3;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_LOCK_BIT = 3;
    localparam int STAT_OSC_BIT  = 4;

    // Reset values
    localparam logic LVL_SEL_RST = 1'b0;

    // Bits of a pin control word
    localparam int CB_OE  = 0;
    localparam int CB_OUT = 1;
    localparam int CB_PU  = 2;
    localparam int CB_IE  = 3;
    localparam int CB_AE  = 4;
    localparam int CB_WK  = 5;
    localparam int CB_W   = 6;

    typedef enum logic [2:0] {
        ST_POR  = 3'h0,
        ST_XRST = 3'h1,
        ST_IRST = 3'h2,
        ST_RUN  = 3'h3,
        ST_STBY = 3'h4,
        ST_DEEP = 3'h5,
        ST_DRET = 3'h6
    } pmpsc_state_t;

    typedef enum logic [1:0] {
        PWR_RUN  = 2'h0,
        PWR_STBY = 2'h1,
        PWR_DEEP = 2'h2,
        PWR_DRET = 2'h3
    } pmpsc_pwr_t;

    typedef enum logic [2:0] {
        FN_GPIO   = 3'h0,
        FN_DEBUG  = 3'h1,
        FN_WAKE   = 3'h2,
        FN_ANALOG = 3'h3,
        FN_EXTINT = 3'h4,
        FN_RESRC  = 3'h5,
        FN_NMI    = 3'h6
    } pmpsc_func_t;

endpackage : pmpsc_pkg

/* File: verilog/pmpsc_sync.sv */
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
module pmpsc_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout   <= '0;
        end else if (ce) begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : pmpsc_sync

/* File: verilog/pmpsc_top.sv */
// Pin state control per power state, with APB configuration registers
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps

// How it works
// - External reset pin keeps pull-up and input enabled in every state.
// - Boot mode pin input buffer stays enabled in every state.
// - Main oscillator input pin input stays enabled in every state.
// - Oscillator output Hi-Z, input 0 in resets or when stopped; else kept.
// - GPIO pins locked during resets; kept as they were in run.
// - In standby and deep standby, level select 0 keeps GPIO pins, 1 gives them Hi-Z, input 0.
// - Debug pins Hi-Z at power-on, pull-up input in resets, then kept.
// - Wakeup pins kept in run/standby, wakeup input in deep, then GPIO.
// - Analog pins Hi-Z at power-on, then Hi-Z, input 0, analog enabled.
// - Interrupt pins locked in resets, kept, GPIO or Hi-Z in deep.
// - NMI pin kept, wakeup input in deep standby, GPIO after exit.
// - Resource pins Hi-Z at power-on, Hi-Z, input in external and internal reset; kept; GPIO or Hi-Z in deep standby.
// - Other peripheral pins Hi-Z with input 0 in standby, select 1.
// - Keeping state means following the peripheral or holding port output.
// - Level select is one bit of the standby mode control register.
module pmpsc_top
    import pmpsc_pkg::*;
#(
    parameter int NPINS = 8
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     ce,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     external_reset_input_n,
    input  wire logic                     int_reset,
    input  wire pmpsc_pkg::pmpsc_pwr_t    pwr_mode,
    input  wire logic                     osc_stopped,
    input  wire logic [NPINS-1:0]         per_oe,
    input  wire logic [NPINS-1:0]         per_out,
    input  wire logic [NPINS-1:0]         pad_in,
    output logic      [NPINS-1:0]         pad_out,
    output logic      [NPINS-1:0]         pad_oe_n,
    output logic      [NPINS-1:0]         pad_pu,
    output logic      [NPINS-1:0]         pad_ie,
    output logic      [NPINS-1:0]         pad_ae,
    output logic      [NPINS-1:0]         wakeup_input_en,
    output logic      [NPINS-1:0]         pin_in_core,
    output logic                          ext_rst_pu,
    output logic                          ext_rst_ie,
    output logic                          mode_pin_ie,
    output logic                          osc_in_ie,
    output logic                          osc_out_oe_n,
    output logic                          osc_out_ie,
    output pmpsc_pkg::pmpsc_state_t       power_state
);
    import pmpsc_pkg::*;

    localparam int FW = NPINS * FUNC_W;

    logic [NPINS:0]      sync_in;
    logic [NPINS:0]      sync_out;
    logic                ext_rst_n_s;
    logic [NPINS-1:0]    pad_s;
    pmpsc_state_t        state_q;
    pmpsc_state_t        state_d;
    logic                lock;
    logic                lvl_sel_q;
    logic [FW-1:0]       func_q;
    logic [NPINS-1:0]    gout_q;
    logic [NPINS-1:0]    goe_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [31:0]         prdata_q;
    logic                setup_edge;
    logic                done;
    logic                cfg_addr;
    logic                mapped;
    logic [31:0]         rdata;
    logic [NPINS-1:0]    pad_out_q;
    logic [NPINS-1:0]    pad_oe_n_q;
    logic [NPINS-1:0]    pad_pu_q;
    logic [NPINS-1:0]    pad_ie_q;
    logic [NPINS-1:0]    pad_ae_q;
    logic [NPINS-1:0]    wake_q;
    logic [NPINS-1:0]    pin_in_q;
    logic                osc_oe_n_q;
    logic                osc_ie_q;

    // Pins from the board are asynchronous
    assign sync_in = {external_reset_input_n, pad_in};

    pmpsc_sync #(
        .W (NPINS + 1)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     (sync_in),
        .dout    (sync_out)
    );

    assign ext_rst_n_s = sync_out[NPINS];
    assign pad_s       = sync_out[NPINS-1:0];

    function automatic logic is_reset_phase(input pmpsc_state_t st);
        is_reset_phase = (st == ST_POR) || (st == ST_XRST) || (st == ST_IRST);
    endfunction : is_reset_phase

    // Control word for one pin; all-zero means Hi-Z with input forced to 0
    function automatic logic [CB_W-1:0] pin_ctrl(
        input pmpsc_func_t  fn,
        input pmpsc_state_t st,
        input logic         lvl_sel,
        input logic         p_oe,
        input logic         p_out,
        input logic         g_oe,
        input logic         g_out
    );
        logic [CB_W-1:0] c;
        logic [CB_W-1:0] gpio_c;
        logic [CB_W-1:0] per_c;
        logic            deep_or_stby;
        c            = '0;
        gpio_c       = '0;
        per_c        = '0;
        deep_or_stby = (st == ST_STBY) || (st == ST_DEEP);
        gpio_c[CB_OE]  = g_oe;
        gpio_c[CB_OUT] = g_out;
        gpio_c[CB_IE]  = 1'b1;
        per_c[CB_OE]   = p_oe;
        per_c[CB_OUT]  = p_out;
        per_c[CB_IE]   = 1'b1;
        case (fn)
            FN_GPIO: begin
                if (!is_reset_phase(st)) begin
                    c = (deep_or_stby && lvl_sel) ? '0 : gpio_c;
                end
            end
            FN_DEBUG: begin
                if (st == ST_XRST || st == ST_IRST) begin
                    c[CB_PU] = 1'b1;
                    c[CB_IE] = 1'b1;
                end else if (st != ST_POR) begin
                    c = per_c;
                end
            end
            FN_WAKE, FN_NMI: begin
                if (st == ST_RUN || st == ST_STBY) begin
                    c = per_c;
                end else if (st == ST_DEEP) begin
                    c        = lvl_sel ? '0 : gpio_c;
                    c[CB_IE] = 1'b1;
                    c[CB_WK] = 1'b1;
                end else if (st == ST_DRET) begin
                    c = gpio_c;
                end
            end
            FN_ANALOG: begin
                c[CB_AE] = (st != ST_POR);
            end
            FN_EXTINT: begin
                if (st == ST_RUN || st == ST_STBY) begin
                    c = per_c;
                end else if (st == ST_DEEP) begin
                    c = lvl_sel ? '0 : gpio_c;
                end else if (st == ST_DRET) begin
                    c = gpio_c;
                end
            end
            FN_RESRC: begin
                case (st)
                    ST_XRST, ST_IRST: c[CB_IE] = 1'b1;
                    ST_RUN:           c = per_c;
                    ST_STBY:          c = lvl_sel ? '0 : per_c;
                    ST_DEEP:          c = lvl_sel ? '0 : gpio_c;
                    ST_DRET:          c = gpio_c;
                    default:          c = '0;
                endcase
            end
            default: c = '0;
        endcase
        pin_ctrl = c;
    endfunction : pin_ctrl

    // Power state follows the reset pin, reset controller and power controller
    always_comb begin
        if (!ext_rst_n_s) begin
            state_d = ST_XRST;
        end else if (int_reset) begin
            state_d = ST_IRST;
        end else begin
            case (pwr_mode)
                PWR_RUN:  state_d = ST_RUN;
                PWR_STBY: state_d = ST_STBY;
                PWR_DEEP: state_d = ST_DEEP;
                PWR_DRET: state_d = ST_DRET;
                default:  state_d = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_POR;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    assign lock = is_reset_phase(state_q);

    // APB: one wait state, answer registered
    assign setup_edge = psel && penable && !pready_q;
    assign done       = psel && penable && pready_q;
    assign cfg_addr   = (paddr == ADDR_FUNC) || (paddr == ADDR_GOUT) || (paddr == ADDR_GOE);
    assign mapped     = cfg_addr || (paddr == ADDR_STBY_CTL) || (paddr == ADDR_STATUS)
                        || (paddr == ADDR_PADIN);

    always_comb begin
        rdata = '0;
        case (paddr)
            ADDR_STBY_CTL: rdata[LVL_SEL_BIT] = lvl_sel_q;
            ADDR_FUNC:     rdata[FW-1:0] = func_q;
            ADDR_GOUT:     rdata[NPINS-1:0] = gout_q;
            ADDR_GOE:      rdata[NPINS-1:0] = goe_q;
            ADDR_STATUS: begin
                rdata[STAT_STATE_LSB +: 3] = state_q;
                rdata[STAT_LOCK_BIT]       = lock;
                rdata[STAT_OSC_BIT]        = osc_stopped;
            end
            ADDR_PADIN:    rdata[NPINS-1:0] = pad_s;
            default:       rdata = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (ce) begin
            pready_q <= setup_edge;
            if (setup_edge) begin
                pslverr_q <= !mapped || (pwrite && cfg_addr && lock);
                prdata_q  <= pwrite ? 32'h0000_0000 : rdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_sel_q <= LVL_SEL_RST;
        end else if (ce && done && pwrite && !pslverr_q && paddr == ADDR_STBY_CTL) begin
            lvl_sel_q <= pwdata[LVL_SEL_BIT];
        end
    end

    // Lock holds software off the pins until the resets end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_q <= '0;
            gout_q <= '0;
            goe_q  <= '0;
        end else if (ce && done && pwrite && !pslverr_q) begin
            if (paddr == ADDR_FUNC) begin
                func_q <= pwdata[FW-1:0];
            end
            if (paddr == ADDR_GOUT) begin
                gout_q <= pwdata[NPINS-1:0];
            end
            if (paddr == ADDR_GOE) begin
                goe_q <= pwdata[NPINS-1:0];
            end
        end
    end

    // all pin controls from one register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_q  <= '0;
            pad_oe_n_q <= '1;
            pad_pu_q   <= '0;
            pad_ie_q   <= '0;
            pad_ae_q   <= '0;
            wake_q     <= '0;
            pin_in_q   <= '0;
        end else if (ce) begin
            for (int i = 0; i < NPINS; i++) begin
                logic [CB_W-1:0] c;
                c = pin_ctrl(pmpsc_func_t'(func_q[i*FUNC_W +: FUNC_W]), state_q, lvl_sel_q,
                             per_oe[i], per_out[i], goe_q[i], gout_q[i]);
                pad_out_q[i]  <= c[CB_OUT];
                pad_oe_n_q[i] <= !c[CB_OE];
                pad_pu_q[i]   <= c[CB_PU];
                pad_ie_q[i]   <= c[CB_IE];
                pad_ae_q[i]   <= c[CB_AE];
                wake_q[i]     <= c[CB_WK];
                // Input buffer off forces the core side to 0
                pin_in_q[i]   <= c[CB_IE] & pad_s[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_oe_n_q <= 1'b1;
            osc_ie_q   <= 1'b0;
        end else if (ce) begin
            osc_oe_n_q <= lock || osc_stopped;
            osc_ie_q   <= !(lock || osc_stopped);
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign pad_out         = pad_out_q;
    assign pad_oe_n        = pad_oe_n_q;
    assign pad_pu          = pad_pu_q;
    assign pad_ie          = pad_ie_q;
    assign pad_ae          = pad_ae_q;
    assign wakeup_input_en = wake_q;
    assign pin_in_core     = pin_in_q;
    assign osc_out_oe_n    = osc_oe_n_q;
    assign osc_out_ie      = osc_ie_q;
    assign power_state     = state_q;

    // fixed pins: held by constant flops, never cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_rst_pu  <= 1'b1;
            ext_rst_ie  <= 1'b1;
            mode_pin_ie <= 1'b1;
            osc_in_ie   <= 1'b1;
        end else if (ce) begin
            ext_rst_pu  <= 1'b1;
            ext_rst_ie  <= 1'b1;
            mode_pin_ie <= 1'b1;
            osc_in_ie   <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rst_pin;
        ext_rst_pu && ext_rst_ie;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin lost pull-up");

    property p_mode_pin;
        mode_pin_ie;
    endproperty
    a_mode_pin: assert property (p_mode_pin) else $error("mode pin input off");

    property p_osc_in;
        osc_in_ie;
    endproperty
    a_osc_in: assert property (p_osc_in) else $error("osc input off");

    property p_osc_out;
        ce && (osc_stopped || lock) |=> osc_out_oe_n && !osc_out_ie;
    endproperty
    a_osc_out: assert property (p_osc_out) else $error("osc out not Hi-Z");

    property p_lock_err;
        ce && setup_edge && pwrite && cfg_addr && lock |=> pslverr && pready;
    endproperty
    a_lock_err: assert property (p_lock_err) else $error("locked write accepted");

    property p_lvl_hiz;
        ce && (state_q == ST_STBY) && lvl_sel_q && func_q[FUNC_W-1:0] == FN_GPIO
            |=> pad_oe_n[0] && !pad_ie[0] && !pin_in_core[0];
    endproperty
    a_lvl_hiz: assert property (p_lvl_hiz) else $error("pin 0 not Hi-Z in standby");

    // Pin 3 is the one the bench sets to analog
    property p_analog;
        ce && (state_q != ST_POR) && func_q[3*FUNC_W +: FUNC_W] == FN_ANALOG
            |=> pad_ae[3] && pad_oe_n[3] && !pin_in_core[3];
    endproperty
    a_analog: assert property (p_analog) else $error("analog pin 3 wrong");

    property p_deep_wake;
        ce && (state_q == ST_DEEP) && func_q[2*FUNC_W +: FUNC_W] == FN_WAKE
            |=> wakeup_input_en[2] && pad_ie[2];
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("wakeup input off");

    property p_stable;
        ce && $stable(state_q) && $stable(func_q) && $stable(goe_q) && $stable(per_oe)
            && $stable(lvl_sel_q)
            ##1 ce && $stable(state_q) && $stable(func_q) && $stable(goe_q)
            && $stable(per_oe) && $stable(lvl_sel_q) |=> $stable(pad_oe_n);
    endproperty
    a_stable: assert property (p_stable) else $error("pin drive glitched");

    c_deep_wake:  cover property (state_q == ST_DEEP && wakeup_input_en != '0);
    c_stby_lvl:   cover property (state_q == ST_STBY && lvl_sel_q);
    c_lock_err:   cover property (pready && pslverr);
    c_deep_ret:   cover property (state_q == ST_DEEP ##[1:20] state_q == ST_DRET);
endmodule : pmpsc_top
